/* File: hdl/standby_ram_consts.vh */
/*
 Constants of the relocatable standby RAM: control window layout,
 configuration bit positions, reset values and array timing.
 Assumes inclusion by the single design file only.
*/
`ifndef STANDBY_RAM_CONSTS_VH
`define STANDBY_RAM_CONSTS_VH

// ==========================================================
// Control window (eight bytes, two APB words)
// ==========================================================
`define CTL_WIN_BYTES      24'h000008
`define CTL_WIN_MASK       24'hfffff8
`define CTL_CFG_TEST_OFF   3'h0
`define CTL_BASE_OFF       3'h4

// ==========================================================
// Configuration register fields
// ==========================================================
`define CFG_STOP_BIT       15
`define CFG_LOCK_BIT       11
`define CFG_PROG_BIT       9
`define CFG_RESET          16'h8200
`define TEST_RESET         16'h0000
`define BASE_HIGH_RESET    8'h00
`define BASE_LOW_RESET     16'h0000

// ==========================================================
// Array timing in system clock cycles
// ==========================================================
`define ARRAY_ACCESS_CYCLES 2
`define HALF_LAST_CNT      2'h1
`define LONG_LAST_CNT      2'h3

`endif

/* File: hdl/relocatable_standby_ram.v */
/*
 Relocatable standby RAM: a fixed control window of four registers
 (base high 8-bit, the rest 16-bit) and a flip-flop array whose base software programs.
 Assumes an APB master on pclk carrying the 24-bit module bus
 address, a level module_map_select from system configuration and
 a synchronous reset request pin from outside the clock domain.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "standby_ram_consts.vh"

// What this block does
// - Array accesses complete in two clock cycles, long writes in four
// - Array base aligned to size, 1/2/4 KB
// - Array overlap hides the control registers
// - Byte, word and long accesses, lanes only
// - Config, test, base high, base low registers
// - Eight-byte window, empty locations read zero
// - Answer only when bit 23 matches mapping
// - Reset: stop, program space, bases, lock clear
// - Sync reset finishes access per size rules
module relocatable_standby_ram
#(
   parameter        ARRAY_BYTES = 1024,        // 1024, 2048 or 4096
   parameter [23:0] CTL_BASE    = 24'hfff000   // Fixed control window
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [23:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   input  wire [2:0]  pprot,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        module_map_select,
   input  wire        sync_reset_req,
   output wire        array_stopped
);

   // ==========================================================
   // Sizing helpers
   // ==========================================================
   // Ceiling log2 of a constant
   function integer clog2;
      input integer value;
      integer v;
      begin
         v = value - 1;
         clog2 = 0;
         while (v > 0)
         begin
            clog2 = clog2 + 1;
            v = v >> 1;
         end
      end
   endfunction

   // Merge new bytes into an old word under a lane mask
   function [31:0] merge_lanes;
      input [31:0] old_word;
      input [31:0] new_word;
      input [3:0]  lanes;
      integer i;
      begin
         merge_lanes = old_word;
         for (i = 0; i < 4; i = i + 1)
            if (lanes[i])
               merge_lanes[i*8 +: 8] = new_word[i*8 +: 8];
      end
   endfunction

   localparam ABITS = clog2(ARRAY_BYTES);   // Byte address bits of array
   localparam DEPTH = ARRAY_BYTES / 4;      // Words in the array
   localparam [23:0] SIZE_MASK = ~((24'h000001 << ABITS) - 24'h000001);

   // ==========================================================
   // State
   // ==========================================================
   reg [31:0] mem [0:DEPTH-1];           // Array storage
   reg [15:0] ram_module_config_reg;     // Stop, lock, program space
   reg [15:0] ram_test_reg;              // Test storage, no effect
   reg [7:0]  array_base_high_reg;       // Base address bits 23:16
   reg [15:0] array_base_low_reg;        // Base address bits 15:0
   reg [1:0]  cnt_reg;                   // Access phase cycle count
   reg        srst_s1_reg;               // Sync reset request stage 1
   reg        srst_s2_reg;               // Sync reset request stage 2
   reg        srst_pend_reg;             // Sync reset waiting to apply

   reg        arr_hit;                   // Array claims the address
   reg        reg_hit;                   // Control window claims it
   reg        bad_map;                   // Mapping or extension mismatch
   reg        is_long;                   // All four lanes or any read: long word
   reg        apply_srst;                // Sync reset takes effect now
   reg [23:0] array_base;                // Aligned array base

   wire       acc  = psel & penable;     // Access phase
   wire       stop = ram_module_config_reg[`CFG_STOP_BIT];
   wire       lock = ram_module_config_reg[`CFG_LOCK_BIT];
   wire       prog = ram_module_config_reg[`CFG_PROG_BIT];
   wire [ABITS-3:0] widx = paddr[ABITS-1:2];

   assign array_stopped = stop;

   // ==========================================================
   // Address decode and ready
   // ==========================================================
   always @*
   begin
      // base forced to a multiple of the array size
      array_base = {array_base_high_reg, array_base_low_reg} & SIZE_MASK;
      // bit 23 must match module mapping; extension checked
      bad_map = (paddr[23] != module_map_select) ||
                (paddr[22:20] != {3{paddr[19]}});
      arr_hit = !bad_map && !stop && !(pprot[2] && !prog) &&
                ((paddr & SIZE_MASK) == array_base);
      // array wins over the control window
      reg_hit = !bad_map && !arr_hit &&
                ((paddr & `CTL_WIN_MASK) == CTL_BASE);
      is_long = (pstrb == 4'hf) || !pwrite;
      pready  = 1'b1;
      pslverr = 1'b0;
      if (arr_hit)
      begin
         // two cycles per word; long write takes two words
         if (is_long && pwrite)
            pready = (cnt_reg == `LONG_LAST_CNT) ||
                     // pending reset stops after upper word
                     (cnt_reg == `HALF_LAST_CNT && srst_pend_reg);
         else
            pready = (cnt_reg == `HALF_LAST_CNT);
      end
      else if (!reg_hit)
         pslverr = 1'b1;             // Not ours: error, zero data
      // reset waits for the array access it may interrupt
      apply_srst = srst_pend_reg && !(acc && arr_hit && !pready);
   end

   // ==========================================================
   // Synchronous reset request capture
   // ==========================================================
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         srst_s1_reg   <= 1'b0;
         srst_s2_reg   <= 1'b0;
         srst_pend_reg <= 1'b0;
      end
      else
      begin
         srst_s1_reg   <= sync_reset_req;
         srst_s2_reg   <= srst_s1_reg;
         srst_pend_reg <= srst_s2_reg | (srst_pend_reg & !apply_srst);
      end
   end

   // ==========================================================
   // Access phase counter
   // ==========================================================
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_reg <= 2'h0;
      else if (acc && arr_hit && !pready)
         cnt_reg <= cnt_reg + 2'h1;   // Still inside the array access
      else
         cnt_reg <= 2'h0;             // Idle or completing
   end

   // ==========================================================
   // Array storage
   // ==========================================================
   // Storage has no reset, so it stays out of the reset process
   always @(posedge pclk)
   begin
      if (acc && arr_hit && pwrite)
      begin
         // byte, word or long; only strobed lanes change
         if (!(pstrb == 4'hf))
         begin
            if (pready)
               mem[widx] <= merge_lanes(mem[widx], pwdata, pstrb);
         end
         // upper word at first half, lower word at second
         else if (cnt_reg == `HALF_LAST_CNT)
            mem[widx] <= merge_lanes(mem[widx], pwdata, 4'hc);
         else if (cnt_reg == `LONG_LAST_CNT)
            mem[widx] <= merge_lanes(mem[widx], pwdata, 4'h3);
      end
   end

   // ==========================================================
   // Read data
   // ==========================================================
   // Read data holds until the next completed read; writes leave it
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (acc && arr_hit && !pwrite && pready)
         prdata <= mem[widx];         // Reads return the whole word
      else if (acc && !arr_hit && !pwrite && pready)
      begin
         // window words; no hit reads zero
         if (reg_hit && paddr[2:0] == `CTL_CFG_TEST_OFF)
            prdata <= {ram_module_config_reg, ram_test_reg};
         else if (reg_hit && paddr[2:0] == `CTL_BASE_OFF)
            prdata <= {8'h00, array_base_high_reg, array_base_low_reg};
         else
            prdata <= 32'h00000000;
      end
   end

   // ==========================================================
   // Control registers
   // ==========================================================
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // stop, program space on, bases and lock cleared
         ram_module_config_reg <= `CFG_RESET;
         ram_test_reg          <= `TEST_RESET;
         array_base_high_reg   <= `BASE_HIGH_RESET;
         array_base_low_reg    <= `BASE_LOW_RESET;
      end
      else if (apply_srst)
      begin
         // same state after a synchronous reset
         ram_module_config_reg <= `CFG_RESET;
         ram_test_reg          <= `TEST_RESET;
         array_base_high_reg   <= `BASE_HIGH_RESET;
         array_base_low_reg    <= `BASE_LOW_RESET;
      end
      else if (acc && pwrite && reg_hit)
      begin
         // four registers, two per word, upper half first
         if (paddr[2:0] == `CTL_CFG_TEST_OFF)
         begin
            if (pstrb[3])
               ram_module_config_reg[15:8] <= pwdata[31:24] |
                                              {4'h0, lock, 3'h0};
            if (pstrb[2])
               ram_module_config_reg[7:0]  <= pwdata[23:16];
            if (pstrb[1])
               ram_test_reg[15:8] <= pwdata[15:8];
            if (pstrb[0])
               ram_test_reg[7:0]  <= pwdata[7:0];
         end
         // Lock freezes the base until reset
         else if (paddr[2:0] == `CTL_BASE_OFF && !lock)
         begin
            if (pstrb[2])
               array_base_high_reg <= pwdata[23:16];
            if (pstrb[1])
               array_base_low_reg[15:8] <= pwdata[15:8];
            if (pstrb[0])
               array_base_low_reg[7:0]  <= pwdata[7:0];
         end
      end
   end

endmodule

/* File: verification/standby_ram_checker.sv */
/* Port checker for the standby RAM.
   Assumes binding to relocatable_standby_ram with its parameters. */
`timescale 1ns/1ps
module standby_ram_checker
#(parameter ARRAY_BYTES = 1024, parameter [23:0] CTL_BASE = 24'hfff000)
(input logic pclk, input logic presetn, input logic psel, input logic penable,
 input logic pwrite, input logic [23:0] paddr, input logic [31:0] pwdata,
 input logic [3:0] pstrb, input logic [2:0] pprot, input logic [31:0] prdata,
 input logic pready, input logic pslverr, input logic module_map_select,
 input logic sync_reset_req, input logic array_stopped);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completing access cycle
   logic done;
   assign done = psel && penable && pready;
   // Completing read cycle
   logic rd_done;
   assign rd_done = done && !pwrite;
   property p_stop_fast; psel && penable && !$past(penable) && array_stopped |-> pready; endproperty
   a_stop_fast: assert property (p_stop_fast) else $error("window access waited");
   property p_map; done && (paddr[23] != module_map_select) |-> pslverr; endproperty
   a_map: assert property (p_map) else $error("map mismatch answered");
   property p_ext; done && (paddr[22:20] != {3{paddr[19]}}) |-> pslverr; endproperty
   a_ext: assert property (p_ext) else $error("bad extension answered");
   property p_bound; psel && penable |-> ##[0:3] pready; endproperty
   a_bound: assert property (p_bound) else $error("access too long");
   property p_wait; done && !pslverr && !array_stopped && (paddr[23:3] != CTL_BASE[23:3]) |-> $past(penable);
   endproperty
   a_wait: assert property (p_wait) else $error("array access without wait");
   property p_hold; !$stable(prdata) |-> $past(rd_done); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_rst; $rose(presetn) |-> array_stopped; endproperty
   a_rst: assert property (p_rst) else $error("not stopped after reset");
   property p_errz; done && pslverr && !pwrite |=> prdata == 32'h0; endproperty
   a_errz: assert property (p_errz) else $error("refused read data");
endmodule
bind relocatable_standby_ram standby_ram_checker #(.ARRAY_BYTES(ARRAY_BYTES), .CTL_BASE(CTL_BASE)) u_chk
(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
 .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
 .module_map_select(module_map_select), .sync_reset_req(sync_reset_req), .array_stopped(array_stopped));

/* File: verification/bus_master_model.sv */
/* Core-side APB master model.
   Assumes pready is settled before each rising edge. */
`timescale 1ns/1ps
module bus_master_model
(input logic pclk, output logic psel, output logic penable, output logic pwrite,
 output logic [23:0] paddr, output logic [31:0] pwdata, output logic [3:0] pstrb,
 output logic [2:0] pprot, input logic pready);
   initial {psel, penable, pwrite, paddr, pwdata, pstrb, pprot} = '0;
   // One transfer, called just after a rising edge
   task automatic xfer(input logic w, input logic [23:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [2:0] p, output logic ok);
      ok = 0;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s; pprot <= p;
      @(posedge pclk) penable <= 1;
      for (int i = 0; i < 20 && !ok; i++)
      begin
         // Answer sampled at the rising edge that ends the cycle
         @(posedge pclk) ok = pready;
      end
      // Released data shows the inverse; one idle edge before the next setup
      psel <= 0; penable <= 0; pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule

/* File: verification/relocatable_standby_ram_test.sv */
/* Self-checking bench for the standby RAM.
   Assumes the control window at 24'hfff000 and a 1 KB array. */
`timescale 1ns/1ps
module relocatable_standby_ram_test;
   localparam [23:0] W = 24'hfff000, B = 24'hfff004, A = 24'hfff400;
   localparam [32:0] OK = 33'h0, ERR = 33'h100000000;
   logic pclk = 0, presetn = 0, mms = 1, srq = 0, ok;
   logic psel, penable, pwrite, pready, pslverr, stopped;
   logic [23:0] paddr;
   logic [31:0] pwdata, prdata, r = 32'he0b7;
   logic [3:0] pstrb;
   logic [2:0] pprot, pp = 0;
   logic [32:0] q[$];
   logic [31:0] mem[4];
   int failures = 0, n_compared = 0;
   always #5 pclk = ~pclk;
   bus_master_model u_m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .pready(pready));
   relocatable_standby_ram u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .module_map_select(mms), .sync_reset_req(srq),
      .array_stopped(stopped));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      if (q.size() != 0) failures++;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Note expectation, then run the transfer
   task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [32:0] e);
      q.push_back(e);
      u_m.xfer(w, a, d, s, pp, ok);
      if (!ok)
      begin
         failures++;
         results();
      end
   endtask
   // Monitor: compare each completion with the oldest note
   always @(negedge pclk)
      if (psel && penable && pready)
      begin : watch
         logic e, w;
         e = pslverr;
         w = pwrite;
         @(posedge pclk) #1 chk({e, w ? 32'h0 : prdata}, q.pop_front());
      end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk({32'h0, stopped}, 33'h1);
      acc(0, W, 0, 4'hf, {1'b0, 32'h82000000});
      acc(0, B, 0, 4'hf, OK);
      acc(0, A, 0, 4'hf, ERR);
      acc(1, W, 32'h02000000, 4'hf, OK);
      acc(1, B, 32'hfffff400, 4'hf, OK);
      acc(0, B, 0, 4'hf, {1'b0, 32'h00fff400});
      $display("test registers done");
      acc(1, A, 32'h11223344, 4'hf, OK);
      acc(1, A, 32'h0000aa00, 4'h2, OK);
      acc(0, A, 0, 4'hf, {1'b0, 32'h1122aa44});
      for (int i = 0; i < 4; i++)
      begin
         r = lfsr(r);
         mem[i] = r;
         acc(1, A + 24'h8 + 4 * i, r, 4'hf, OK);
      end
      for (int i = 0; i < 4; i++) acc(0, A + 24'h8 + 4 * i, 0, 4'hf, {1'b0, mem[i]});
      $display("test array done");
      acc(0, 24'h8ff000, 0, 4'hf, ERR);
      acc(1, 24'hfff008, 32'h1, 4'hf, ERR);
      mms <= 0;
      acc(0, W, 0, 4'hf, ERR);
      mms <= 1;
      acc(1, W, 32'h0, 4'hf, OK);
      pp = 3'h4;
      acc(0, A, 0, 4'hf, ERR);
      pp = 0;
      acc(1, W, 32'h08000000, 4'hf, OK);
      acc(1, B, 32'h0000f800, 4'hf, OK);
      acc(0, B, 0, 4'hf, {1'b0, 32'h00fff400});
      srq <= 1;
      repeat (4) @(posedge pclk);
      srq <= 0;
      repeat (3) @(posedge pclk);
      acc(0, W, 0, 4'hf, {1'b0, 32'h82000000});
      acc(1, W, 32'h0, 4'hf, OK);
      acc(1, B, 32'h00fff000, 4'hf, OK);
      acc(1, B, 32'h12345678, 4'hf, OK);
      acc(0, B, 0, 4'hf, {1'b0, 32'h12345678});
      srq <= 1;
      @(posedge pclk);
      srq <= 0;
      acc(1, B, 32'h9abcdef0, 4'hf, OK);
      acc(1, W, 32'h0, 4'hf, OK);
      acc(1, B, 32'h00fff000, 4'hf, OK);
      acc(0, B, 0, 4'hf, {1'b0, 32'h9abc5678});
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      acc(0, W, 0, 4'hf, {1'b0, 32'h82000000});
      $display("test reset done");
      repeat (3) @(posedge pclk);
      results();
   end
endmodule
